//--- hdl/hsir_pkg.sv
package hsir_pkg;

	// ****************************************************************
	// Register map of the control port.
	// ****************************************************************
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h01;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h02;
	localparam logic [7:0] ADDR_RX_INFO = 8'h03;

	// ****************************************************************
	// Field positions.
	// ****************************************************************
	localparam int CTRL_RX_RESET_BIT = 6;
	localparam int ST_CODE_CHANGE = 7;
	localparam int ST_PKT_END = 6;
	localparam int ST_PKT_START = 5;
	localparam int ST_RX_HALF = 4;
	localparam int ST_RX_NOT_EMPTY = 3;
	localparam int ST_TX_HALF_EMPTY = 2;
	localparam int ST_TX_NOT_FULL = 1;
	localparam int ST_TX_MSG_END = 0;
	localparam int RI_ABORT = 7;
	localparam int RI_CRC_ERR = 6;
	localparam int RI_OVERRUN = 5;
	localparam int RI_VALID_MSG = 4;
	localparam int RI_EMPTY = 3;
	localparam int RI_PKT_OK = 2;
	localparam int RI_CLOSING = 1;
	localparam int RI_OPENING = 0;

	// ****************************************************************
	// Reset values and FIFO geometry.
	// ****************************************************************
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [6:0] FIFO_DEPTH = 7'h40;
	localparam logic [6:0] FIFO_HALF = 7'h20;

endpackage

//--- hdl/hsir_regs.sv
// How it works
// - Code-change bit sets whenever the code detector gains or loses a valid code.
// - Packet-end bit sets when the receive engine finishes any packet.
// - Packet-start bit sets when the receive engine sees an opening byte.
// - Receive half-full is high while receive occupancy exceeds thirty-two bytes.
// - Receive not-empty is high while at least one byte waits in the FIFO.
// - Transmit not-full is high while the transmit FIFO has room.
// - Latched status bits hold until a read of the status register clears them.
// - Mask bit zero blocks its status bit, one lets it interrupt.
// - Abort bit sets when seven or more ones in a row are seen.
// - Checksum-error bit sets when a packet's CRC does not match.
// - Overrun bit sets when the engine writes into a full receive FIFO.
// - Valid-message bit sets once a complete packet is detected and checked.
// - Receive-empty bit is live, high exactly while the FIFO is empty.
// - Packet-ok shows the read-port byte ends a clean message.
// - Closing-byte shows the read-port byte ends any message.
// - Opening-byte shows the read-port byte starts a message.
// - Latched receive-info bits hold until a read of that register clears them.
// - Rising edge of the receive reset control resets the receive engine once.
module hsir_regs
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	output logic [7:0] cpu_rdata,
	input wire logic code_detected_live,
	input wire logic rx_packet_end,
	input wire logic rx_packet_start,
	input wire logic [6:0] rx_fifo_level,
	input wire logic [6:0] tx_fifo_level,
	input wire logic tx_message_end,
	input wire logic rx_abort_seen,
	input wire logic rx_checksum_error,
	input wire logic rx_overrun,
	input wire logic rx_valid_message,
	input wire logic rx_packet_ok,
	input wire logic rx_closing_byte,
	input wire logic rx_opening_byte,
	output logic irq,
	output logic rx_engine_reset
);

	// ****************************************************************
	// Address decode.
	// ****************************************************************
	wire logic sel_control;
	wire logic sel_status;
	wire logic sel_mask;
	wire logic sel_info;
	assign sel_control = cpu_addr == hsir_pkg::ADDR_CONTROL;
	assign sel_status = cpu_addr == hsir_pkg::ADDR_STATUS;
	assign sel_mask = cpu_addr == hsir_pkg::ADDR_IRQ_MASK;
	assign sel_info = cpu_addr == hsir_pkg::ADDR_RX_INFO;

	wire logic rd_status;
	wire logic rd_info;
	assign rd_status = cpu_rd && sel_status;
	assign rd_info = cpu_rd && sel_info;

	logic [7:0] link_ctrl_control_reg;
	logic [7:0] link_ctrl_irq_mask_reg;
	logic code_prev;
	logic lat_code_change;
	logic lat_pkt_end;
	logic lat_pkt_start;
	logic lat_tx_msg_end;
	logic lat_abort;
	logic lat_crc_err;
	logic lat_overrun;
	logic lat_valid_msg;

	// ****************************************************************
	// Live status conditions.
	// ****************************************************************
	wire logic code_toggle;
	wire logic rx_half_full;
	wire logic rx_not_empty;
	wire logic tx_half_empty;
	wire logic tx_not_full;
	wire logic rx_empty;
	assign code_toggle = code_detected_live != code_prev;
	assign rx_half_full = rx_fifo_level > hsir_pkg::FIFO_HALF;
	assign rx_not_empty = rx_fifo_level != 7'h00;
	assign tx_half_empty = tx_fifo_level < hsir_pkg::FIFO_HALF;
	assign tx_not_full = tx_fifo_level < hsir_pkg::FIFO_DEPTH;
	assign rx_empty = rx_fifo_level == 7'h00;

	// A latched bit sets over a clearing read so no event is lost.
	wire logic next_code_change;
	wire logic next_pkt_end;
	wire logic next_pkt_start;
	wire logic next_tx_msg_end;
	wire logic next_abort;
	wire logic next_crc_err;
	wire logic next_overrun;
	wire logic next_valid_msg;
	assign next_code_change = code_toggle || (lat_code_change && !rd_status);
	assign next_pkt_end = rx_packet_end || (lat_pkt_end && !rd_status);
	assign next_pkt_start = rx_packet_start || (lat_pkt_start && !rd_status);
	assign next_tx_msg_end = tx_message_end || (lat_tx_msg_end && !rd_status);
	assign next_abort = rx_abort_seen || (lat_abort && !rd_info);
	assign next_crc_err = rx_checksum_error || (lat_crc_err && !rd_info);
	assign next_overrun = rx_overrun || (lat_overrun && !rd_info);
	assign next_valid_msg = rx_valid_message || (lat_valid_msg && !rd_info);

	wire logic [7:0] status_view;
	wire logic [7:0] info_view;
	assign status_view = {lat_code_change, lat_pkt_end, lat_pkt_start, rx_half_full,
		rx_not_empty, tx_half_empty, tx_not_full, lat_tx_msg_end};
	assign info_view = {lat_abort, lat_crc_err, lat_overrun, lat_valid_msg,
		rx_empty, rx_packet_ok, rx_closing_byte, rx_opening_byte};

	wire logic [7:0] next_rdata;
	assign next_rdata = sel_control ? link_ctrl_control_reg :
		sel_status ? status_view :
		sel_mask ? link_ctrl_irq_mask_reg :
		sel_info ? info_view : hsir_pkg::RESET_BYTE;

	wire logic next_irq;
	wire logic next_rx_reset;
	assign next_irq = |(status_view & link_ctrl_irq_mask_reg);
	assign next_rx_reset = cpu_wr && sel_control && cpu_wdata[hsir_pkg::CTRL_RX_RESET_BIT]
		&& !link_ctrl_control_reg[hsir_pkg::CTRL_RX_RESET_BIT];

	// ****************************************************************
	// Registers.
	// ****************************************************************
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			link_ctrl_control_reg <= hsir_pkg::RESET_BYTE;
			link_ctrl_irq_mask_reg <= hsir_pkg::RESET_BYTE;
		end
		else if (cpu_wr && sel_control)
			link_ctrl_control_reg <= cpu_wdata;
		else if (cpu_wr && sel_mask)
			link_ctrl_irq_mask_reg <= cpu_wdata;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			code_prev <= 1'h0;
			{lat_code_change, lat_pkt_end, lat_pkt_start, lat_tx_msg_end} <= 4'h0;
			{lat_abort, lat_crc_err, lat_overrun, lat_valid_msg} <= 4'h0;
		end
		else
		begin
			code_prev <= code_detected_live;
			{lat_code_change, lat_pkt_end, lat_pkt_start, lat_tx_msg_end} <=
				{next_code_change, next_pkt_end, next_pkt_start, next_tx_msg_end};
			{lat_abort, lat_crc_err, lat_overrun, lat_valid_msg} <=
				{next_abort, next_crc_err, next_overrun, next_valid_msg};
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			cpu_rdata <= hsir_pkg::RESET_BYTE;
			irq <= 1'h0;
			rx_engine_reset <= 1'h0;
		end
		else
		begin
			cpu_rdata <= next_rdata;
			irq <= next_irq;
			rx_engine_reset <= next_rx_reset;
		end
	end

endmodule // hsir_regs

//--- dv/hsir_regs_properties.sv
module hsir_regs_properties
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [7:0] cpu_rdata,
	input wire logic code_detected_live,
	input wire logic rx_packet_end,
	input wire logic [6:0] rx_fifo_level,
	input wire logic rx_abort_seen,
	input wire logic irq,
	input wire logic rx_engine_reset
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	// A read between the event and the checked read would clear the bit, so it is excluded.
	wire logic rd_st = cpu_rd && cpu_addr == 8'h01;
	wire logic rd_ri = cpu_rd && cpu_addr == 8'h03;
	a_code_change: assert property ($changed(code_detected_live) ##1 !rd_st ##1 rd_st |=> cpu_rdata[7])
		else $error("code change lost");
	a_pkt_end_latch: assert property (rx_packet_end ##1 !rd_st ##1 rd_st |=> cpu_rdata[6])
		else $error("packet end lost");
	a_rx_half: assert property (rd_st |=> cpu_rdata[4] == ($past(rx_fifo_level) > 7'h20))
		else $error("half full wrong");
	a_status_clear: assert property (rd_st && !rx_packet_end ##1 rd_st |=> !cpu_rdata[6])
		else $error("status not cleared");
	a_mask_off: assert property (cpu_wr && cpu_addr == 8'h02 && cpu_wdata == 8'h00 |=> ##1 !irq)
		else $error("masked irq");
	a_abort_latch: assert property (rx_abort_seen ##1 rd_ri |=> cpu_rdata[7])
		else $error("abort lost");
	a_info_clear: assert property (rd_ri && !rx_abort_seen ##1 !rx_abort_seen ##1 rd_ri |=> !cpu_rdata[7])
		else $error("info not cleared");
	a_reset_pulse: assert property (rx_engine_reset |-> $past(cpu_wr) && $past(cpu_addr) == 8'h00 ##1 !rx_engine_reset)
		else $error("bad engine reset");
	cover property (rx_engine_reset);
	cover property (irq);
	cover property (rd_st ##1 rd_st);
endmodule // hsir_regs_properties

//--- dv/tb_hsir_regs.sv
module tb_hsir_regs;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {logic [6:0] rl; logic [6:0] tl; logic [3:0] st; logic em;} hsir_row_t;
	logic core_clk = 1'h0, rst = 1'h1, cpu_wr = 1'h0, cpu_rd = 1'h0, irq, rx_engine_reset;
	logic [7:0] cpu_addr = 8'h00, cpu_wdata = 8'h00, cpu_rdata, d;
	logic [6:0] rx_fifo_level = 7'h00, tx_fifo_level = 7'h00;
	logic code_detected_live = 1'h0, rx_packet_end = 1'h0, rx_packet_start = 1'h0, tx_message_end = 1'h0;
	logic rx_abort_seen = 1'h0, rx_checksum_error = 1'h0, rx_overrun = 1'h0, rx_valid_message = 1'h0;
	logic rx_packet_ok = 1'h0, rx_closing_byte = 1'h0, rx_opening_byte = 1'h0;
	int n_fail = 0, checks_done = 0, pulses = 0;
	hsir_row_t rows [6] = '{'{7'h00, 7'h00, 4'h3, 1'h1}, '{7'h01, 7'h1f, 4'h7, 1'h0}, '{7'h20, 7'h20, 4'h5, 1'h0},
		'{7'h21, 7'h3f, 4'hd, 1'h0}, '{7'h40, 7'h40, 4'hc, 1'h0}, '{7'h00, 7'h40, 4'h0, 1'h1}};
	logic [7:0] seq_a [5] = '{8'h03, 8'h01, 8'h03, 8'h01, 8'h01};
	logic [7:0] seq_e [5] = '{8'hff, 8'he1, 8'h08, 8'h00, 8'h00};
	logic [7:0] ctl [4] = '{8'h40, 8'h40, 8'h00, 8'h40};
	always #2 core_clk = ~core_clk;
	always @(posedge core_clk) pulses <= pulses + int'(rx_engine_reset);
	hsir_regs i_dut (.*);
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// Strobes stay up between calls so back-to-back accesses of the same kind never toggle them in one step.
	task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] w);
		cpu_wr = wr;
		cpu_rd = !wr;
		cpu_addr = a;
		cpu_wdata = w;
		@(posedge core_clk);
		#1;
		d = cpu_rdata;
	endtask
	task automatic idle(input int n);
		cpu_wr = 1'h0;
		cpu_rd = 1'h0;
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic end_sim;
		if (n_fail == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		#100000;
		n_fail++;
		end_sim();
	end
	initial
	begin
		idle(10);
		check(cpu_rdata | {7'h00, irq | rx_engine_reset}, 8'h00);
		rst = 1'h0;
		foreach (rows[i])
		begin
			rx_fifo_level = rows[i].rl;
			tx_fifo_level = rows[i].tl;
			idle(2);
			acc(1'h0, 8'h01, 8'h00);
			check({4'h0, d[4:1]}, {4'h0, rows[i].st});
			acc(1'h0, 8'h03, 8'h00);
			check({7'h00, d[3]}, {7'h00, rows[i].em});
		end
		{code_detected_live, rx_packet_end, rx_packet_start, tx_message_end} = 4'hf;
		{rx_abort_seen, rx_checksum_error, rx_overrun, rx_valid_message} = 4'hf;
		{rx_packet_ok, rx_closing_byte, rx_opening_byte} = 3'h7;
		idle(1);
		{rx_packet_end, rx_packet_start, tx_message_end, rx_abort_seen} = 4'h0;
		{rx_checksum_error, rx_overrun, rx_valid_message} = 3'h0;
		foreach (seq_a[j])
		begin
			acc(1'h0, seq_a[j], 8'h00);
			check(d, seq_e[j]);
			if (j == 0)
				{rx_packet_ok, rx_closing_byte, rx_opening_byte} = 3'h0;
		end
		acc(1'h1, 8'h02, 8'h40);
		acc(1'h0, 8'h02, 8'h00);
		check(d, 8'h40);
		rx_packet_end = 1'h1;
		idle(1);
		rx_packet_end = 1'h0;
		idle(2);
		check({7'h00, irq}, 8'h01);
		acc(1'h1, 8'h02, 8'h00);
		idle(2);
		check({7'h00, irq}, 8'h00);
		rx_packet_end = 1'h1;
		acc(1'h0, 8'h01, 8'h00);
		rx_packet_end = 1'h0;
		acc(1'h0, 8'h01, 8'h00);
		check(d & 8'h40, 8'h40);
		acc(1'h1, 8'h03, 8'hff);
		acc(1'h0, 8'h10, 8'h00);
		check(d, 8'h00);
		acc(1'h0, 8'h03, 8'h00);
		check(d, 8'h08);
		foreach (ctl[k])
			acc(1'h1, 8'h00, ctl[k]);
		idle(2);
		check(8'(pulses), 8'h02);
		end_sim();
	end
endmodule // tb_hsir_regs
bind hsir_regs hsir_regs_properties i_props (.*);
